// file: rtl/lccr_defines.svh
`ifndef LCCR_DEFINES_SVH
`define LCCR_DEFINES_SVH

// register offsets
`define LCCR_ADDR_CTRL 8'h10
`define LCCR_ADDR_CHOPT 8'h13
`define LCCR_ADDR_DRV 8'h15
`define LCCR_ADDR_FLT 8'h16
`define LCCR_ADDR_MODE 8'h1C

// field positions
`define LCCR_BIT_CTRL_MODESEL 0
`define LCCR_BIT_SENSE_RANGE 2
`define LCCR_BIT_ANALOG_MOD 3
`define LCCR_BIT_REF_SWAP 6
`define LCCR_BIT_POLARITY 7
`define LCCR_DRV_CUR_MSB 5
`define LCCR_GAIN_MSB 7
`define LCCR_GAIN_LSB 6
`define LCCR_BIT_OSC_MASK 0
`define LCCR_BIT_CHON_MASK 1
`define LCCR_BIT_SIM_OVT 4
`define LCCR_BIT_SIM_OVC 5
`define LCCR_BIT_SIM_OSC 7
`define LCCR_MODE_MSB 1
`define LCCR_BIT_PIN_STATE 2

// reset values
`define LCCR_RST_CTRL 8'h00
`define LCCR_RST_CHOPT 8'h40
`define LCCR_RST_DRV 8'h00
`define LCCR_RST_FLT 8'h02
`define LCCR_RST_MODE 8'h05

// writable bits, all others read as zero
`define LCCR_WMASK_CTRL 8'h01
`define LCCR_WMASK_CHOPT 8'hCC
`define LCCR_WMASK_DRV 8'hFF
`define LCCR_WMASK_FLT 8'hB3
`define LCCR_WMASK_MODE 8'h07

// mode field codes
`define LCCR_MODE_OPERATE 2'h1
`define LCCR_MODE_CONFIG 2'h2

// amplification factors per gain code
`define LCCR_GAIN_X2 6'h02
`define LCCR_GAIN_X5 6'h05
`define LCCR_GAIN_X10 6'h0A
`define LCCR_GAIN_X50 6'h32

`endif

// file: rtl/lccr_pkg.sv
package lccr_pkg;

   // decoded operating mode
   typedef enum logic [1:0] {
      LCCR_ILLEGAL,
      LCCR_OPERATE,
      LCCR_CONFIG
   } lccr_mode_t;

   // register access request from the serial front end
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lccr_req_t;

   // register read answer
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lccr_rsp_t;

   // raw fault events from the analog side
   typedef struct packed {
      logic osc_error;
      logic channel_enabled;
      logic overtemp;
      logic overcurrent;
   } lccr_evt_t;

   // configuration applied to the laser channel
   typedef struct packed {
      logic control_mode_select;
      logic sense_range_select;
      logic analog_mod_enable;
      logic reference_swap;
      logic laser_polarity_select;
      logic [5:0] converter_drive_current;
      logic [1:0] sense_gain_select;
      logic [5:0] sense_gain_factor;
   } lccr_cfg_t;

   // whole state of the register bank
   typedef struct packed {
      logic [7:0] ctrl_ff;
      logic [7:0] channel_options_ff;
      logic [7:0] converter_drive_and_gain_ff;
      logic [7:0] fault_mask_and_simulate_ff;
      logic [7:0] mode_and_pin_control_ff;
      lccr_cfg_t applied_ff;
      lccr_evt_t sync1_ff;
      lccr_evt_t sync2_ff;
      lccr_rsp_t rsp_ff;
      lccr_evt_t eff_evt_ff;
      logic fault_check_output_n_ff;
      logic pin_oe_ff;
      logic mem_error_ff;
      lccr_mode_t mode_ff;
   } lccr_state_t;

endpackage : lccr_pkg

// file: rtl/lccr_regs.sv
//Contract
//- bit 3 at 0x13 enables analog modulation
//- bit 6 at 0x13 swaps reference, reset one
//- bit 7 at 0x13 picks N or P laser
//- 0x15 bits 5:0 set converter current linearly
//- 0x15 bits 7:6 choose gain 2/5/10/50
//- 0x16 bit 0 masks oscillator error
//- 0x16 bit 1 masks channel-on monitor
//- 0x16 bit 4 simulates overtemperature
//- 0x16 bit 5 simulates overcurrent
//- 0x16 bit 7 simulates oscillator failure
//- mode codes 00 and 11 flag memory error
//- mode 01 applies configuration transparently
//- mode 10 holds last applied configuration
//- 0x1C bit 2 low pulls pin low
//- control mode select: power or current
//- sense range select: low or supply-referenced
`timescale 1ns/1ps
`include "lccr_defines.svh"

module lccr_regs #(
   parameter int REG_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire lccr_pkg::lccr_req_t req,
   input wire lccr_pkg::lccr_evt_t evt_in,
   output lccr_pkg::lccr_rsp_t rsp,
   output lccr_pkg::lccr_cfg_t cfg,
   output lccr_pkg::lccr_evt_t eff_evt,
   output logic fault_check_output_n,
   output logic analog_input_pin_out,
   output logic analog_input_pin_oe,
   output logic mem_error,
   output lccr_pkg::lccr_mode_t op_mode
);

   // the register map is byte wide by construction
   if (REG_W != 8) begin : g_width_check
      $error("lccr_regs supports only REG_W = 8");
   end

   lccr_pkg::lccr_state_t s_ff;
   lccr_pkg::lccr_state_t nxt_s;

   // gain code to amplification factor
   function automatic logic [5:0] gain_factor(input logic [1:0] code);
      logic [5:0] f;
      f = `LCCR_GAIN_X2;
      case (code)
         2'h0: f = `LCCR_GAIN_X2;
         2'h1: f = `LCCR_GAIN_X5;
         2'h2: f = `LCCR_GAIN_X10;
         2'h3: f = `LCCR_GAIN_X50;
         default: f = `LCCR_GAIN_X2;
      endcase
      return f;
   endfunction : gain_factor

   // build the channel configuration from the current register values
   function automatic lccr_pkg::lccr_cfg_t build_cfg(
      input logic [7:0] ctrl,
      input logic [7:0] opt,
      input logic [7:0] drv
   );
      lccr_pkg::lccr_cfg_t c;
      c = '0;
      // power control when clear, current control when set
      c.control_mode_select = ctrl[`LCCR_BIT_CTRL_MODESEL];
      // low range when clear, supply-referenced when set
      c.sense_range_select = opt[`LCCR_BIT_SENSE_RANGE];
      c.analog_mod_enable = opt[`LCCR_BIT_ANALOG_MOD];
      c.reference_swap = opt[`LCCR_BIT_REF_SWAP];
      c.laser_polarity_select = opt[`LCCR_BIT_POLARITY];
      c.converter_drive_current = drv[`LCCR_DRV_CUR_MSB:0];
      c.sense_gain_select = drv[`LCCR_GAIN_MSB:`LCCR_GAIN_LSB];
      c.sense_gain_factor = gain_factor(c.sense_gain_select);
      return c;
   endfunction : build_cfg

   // read multiplexer, unmapped offsets and unlisted bits give zero
   function automatic logic [7:0] read_mux(
      input lccr_pkg::lccr_state_t s,
      input logic [7:0] addr
   );
      logic [7:0] d;
      d = 8'h00;
      case (addr)
         `LCCR_ADDR_CTRL: d = s.ctrl_ff & `LCCR_WMASK_CTRL;
         `LCCR_ADDR_CHOPT: d = s.channel_options_ff & `LCCR_WMASK_CHOPT;
         `LCCR_ADDR_DRV: d = s.converter_drive_and_gain_ff;
         `LCCR_ADDR_FLT: d = s.fault_mask_and_simulate_ff & `LCCR_WMASK_FLT;
         `LCCR_ADDR_MODE: d = s.mode_and_pin_control_ff & `LCCR_WMASK_MODE;
         default: d = 8'h00;
      endcase
      return d;
   endfunction : read_mux

   // decode the two-bit mode field
   function automatic lccr_pkg::lccr_mode_t decode_mode(
      input logic [1:0] code
   );
      lccr_pkg::lccr_mode_t m;
      m = lccr_pkg::LCCR_ILLEGAL;
      case (code)
         `LCCR_MODE_OPERATE: m = lccr_pkg::LCCR_OPERATE;
         `LCCR_MODE_CONFIG: m = lccr_pkg::LCCR_CONFIG;
         default: m = lccr_pkg::LCCR_ILLEGAL;
      endcase
      return m;
   endfunction : decode_mode

   // next-state logic for the whole bank
   always_comb begin
      logic [7:0] flt;
      logic osc_eff;
      logic ovt_eff;
      logic ovc_eff;
      logic fault;
      lccr_pkg::lccr_mode_t mode;
      flt = s_ff.fault_mask_and_simulate_ff;
      osc_eff = 1'b0;
      ovt_eff = 1'b0;
      ovc_eff = 1'b0;
      fault = 1'b0;
      mode = decode_mode(s_ff.mode_and_pin_control_ff[`LCCR_MODE_MSB:0]);
      nxt_s = s_ff;

      // two-stage synchroniser for the analog-side events
      nxt_s.sync1_ff = evt_in;
      nxt_s.sync2_ff = s_ff.sync1_ff;

      // byte writes store only the listed bits
      if (req.wr_en) begin
         case (req.addr)
            `LCCR_ADDR_CTRL: begin
               nxt_s.ctrl_ff = req.wdata & `LCCR_WMASK_CTRL;
            end
            `LCCR_ADDR_CHOPT: begin
               nxt_s.channel_options_ff =
                  req.wdata & `LCCR_WMASK_CHOPT;
            end
            `LCCR_ADDR_DRV: begin
               nxt_s.converter_drive_and_gain_ff =
                  req.wdata & `LCCR_WMASK_DRV;
            end
            `LCCR_ADDR_FLT: begin
               nxt_s.fault_mask_and_simulate_ff =
                  req.wdata & `LCCR_WMASK_FLT;
            end
            `LCCR_ADDR_MODE: begin
               nxt_s.mode_and_pin_control_ff =
                  req.wdata & `LCCR_WMASK_MODE;
            end
            default: begin
               nxt_s.ctrl_ff = s_ff.ctrl_ff;
            end
         endcase
      end

      // read answer one cycle after the request
      nxt_s.rsp_ff.valid = req.rd_en;
      if (req.rd_en) begin
         nxt_s.rsp_ff.data = read_mux(s_ff, req.addr);
      end else begin
         nxt_s.rsp_ff.data = 8'h00;
      end

      // operating mode and memory error
      nxt_s.mode_ff = mode;
      nxt_s.mem_error_ff = (mode == lccr_pkg::LCCR_ILLEGAL);

      // configuration latch: transparent in operation, held otherwise
      case (mode)
         lccr_pkg::LCCR_OPERATE: begin
            nxt_s.applied_ff = build_cfg(s_ff.ctrl_ff,
               s_ff.channel_options_ff,
               s_ff.converter_drive_and_gain_ff);
         end
         lccr_pkg::LCCR_CONFIG: begin
            nxt_s.applied_ff = s_ff.applied_ff;
         end
         default: begin
            nxt_s.applied_ff = s_ff.applied_ff;
         end
      endcase

      // events as seen by the channel, real or simulated
      osc_eff = s_ff.sync2_ff.osc_error | flt[`LCCR_BIT_SIM_OSC];
      ovt_eff = s_ff.sync2_ff.overtemp | flt[`LCCR_BIT_SIM_OVT];
      ovc_eff = s_ff.sync2_ff.overcurrent
         | flt[`LCCR_BIT_SIM_OVC];
      nxt_s.eff_evt_ff.osc_error = osc_eff;
      nxt_s.eff_evt_ff.overtemp = ovt_eff;
      nxt_s.eff_evt_ff.overcurrent = ovc_eff;
      nxt_s.eff_evt_ff.channel_enabled = s_ff.sync2_ff.channel_enabled;

      // fault check output, low while any unmasked condition stands
      fault = ovt_eff | ovc_eff | (mode == lccr_pkg::LCCR_ILLEGAL);
      if (!flt[`LCCR_BIT_OSC_MASK]) begin
         fault = fault | osc_eff;
      end
      if (!flt[`LCCR_BIT_CHON_MASK]) begin
         fault = fault | s_ff.sync2_ff.channel_enabled;
      end
      nxt_s.fault_check_output_n_ff = ~fault;

      // open-collector pin: drive low when the state bit is clear
      nxt_s.pin_oe_ff =
         ~s_ff.mode_and_pin_control_ff[`LCCR_BIT_PIN_STATE];
   end

   // state register with synchronous reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.ctrl_ff <= `LCCR_RST_CTRL;
         s_ff.channel_options_ff <= `LCCR_RST_CHOPT;
         s_ff.converter_drive_and_gain_ff <= `LCCR_RST_DRV;
         s_ff.fault_mask_and_simulate_ff <= `LCCR_RST_FLT;
         s_ff.mode_and_pin_control_ff <= `LCCR_RST_MODE;
         s_ff.applied_ff <= '0;
         s_ff.applied_ff.reference_swap <= 1'b1;
         s_ff.applied_ff.sense_gain_factor <= `LCCR_GAIN_X2;
         s_ff.fault_check_output_n_ff <= 1'b1;
         s_ff.pin_oe_ff <= 1'b0;
         s_ff.mode_ff <= lccr_pkg::LCCR_OPERATE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state flip-flops, except the pin level which is tied low
   assign rsp = s_ff.rsp_ff;
   assign cfg = s_ff.applied_ff;
   assign eff_evt = s_ff.eff_evt_ff;
   assign fault_check_output_n = s_ff.fault_check_output_n_ff;
   assign analog_input_pin_out = 1'b0; // open collector only pulls low
   assign analog_input_pin_oe = s_ff.pin_oe_ff;
   assign mem_error = s_ff.mem_error_ff;
   assign op_mode = s_ff.mode_ff;

endmodule : lccr_regs

// file: bench/lccr_sva.sv
`timescale 1ns/1ps
module lccr_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire lccr_pkg::lccr_req_t req,
   input wire lccr_pkg::lccr_evt_t evt_in,
   input wire lccr_pkg::lccr_rsp_t rsp,
   input wire lccr_pkg::lccr_cfg_t cfg,
   input wire lccr_pkg::lccr_evt_t eff_evt,
   input wire logic fault_check_output_n,
   input wire logic analog_input_pin_out,
   input wire logic analog_input_pin_oe,
   input wire logic mem_error,
   input wire lccr_pkg::lccr_mode_t op_mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic wr_mode, wr_flt, wr_opt;
   // write decodes for the watched registers
   assign wr_mode = req.wr_en && req.addr == 8'h1C;
   assign wr_flt = req.wr_en && req.addr == 8'h16;
   assign wr_opt = req.wr_en && req.addr == 8'h13;
   chk_rd_answer: assert property (req.rd_en |=> rsp.valid)
      else $error("read got no answer");
   chk_rsp_quiet: assert property (
      !req.rd_en |=> !rsp.valid && rsp.data == 8'h00)
      else $error("answer without read");
   chk_mode_illegal: assert property (
      wr_mode && (req.wdata[1:0] == 2'h0 || req.wdata[1:0] == 2'h3)
      |-> ##2 mem_error)
      else $error("illegal mode not flagged");
   chk_pin_pull: assert property (
      wr_mode && !req.wdata[2] |-> ##2 analog_input_pin_oe)
      else $error("pin not pulled");
   chk_pin_level: assert property (analog_input_pin_out == 1'b0)
      else $error("pin driven high");
   chk_sim_ovt: assert property (
      wr_flt && req.wdata[4] |-> ##2 eff_evt.overtemp)
      else $error("overtemp sim lost");
   chk_sim_ovc: assert property (
      wr_flt && req.wdata[5] |-> ##2 eff_evt.overcurrent)
      else $error("overcurrent sim lost");
   chk_sim_osc: assert property (
      wr_flt && req.wdata[7] |-> ##2 eff_evt.osc_error)
      else $error("osc sim lost");
   chk_fault_low: assert property (
      eff_evt.overtemp || eff_evt.overcurrent || mem_error
      |-> !fault_check_output_n)
      else $error("fault output not low");
   chk_cfg_hold: assert property (
      op_mode == lccr_pkg::LCCR_CONFIG ##1
      op_mode == lccr_pkg::LCCR_CONFIG |-> $stable(cfg))
      else $error("config changed while held");
   chk_cfg_apply: assert property (
      wr_opt ##1 !wr_opt ##1 op_mode == lccr_pkg::LCCR_OPERATE |->
      cfg.laser_polarity_select == $past(req.wdata[7], 2)
      && cfg.analog_mod_enable == $past(req.wdata[3], 2))
      else $error("options not applied");
   chk_gain_map: assert property (cfg.sense_gain_factor ==
      (cfg.sense_gain_select == 2'h0 ? 6'h02 :
       cfg.sense_gain_select == 2'h1 ? 6'h05 :
       cfg.sense_gain_select == 2'h2 ? 6'h0A : 6'h32))
      else $error("gain factor wrong");
   cover property (wr_mode && req.wdata[1:0] == 2'h2);
   cover property (mem_error);
   cover property (!fault_check_output_n);
   cover property (rsp.valid);
endmodule : lccr_sva

// file: bench/lccr_host.sv
`timescale 1ns/1ps
module lccr_host (
   input wire logic clk_sys,
   input wire lccr_pkg::lccr_rsp_t rsp,
   output lccr_pkg::lccr_req_t req
);
   initial req = '0;
   // single byte write, held over exactly one taking edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      req = {2'b10, a, d};
      @(posedge clk_sys);
      #1;
      req = {2'b00, ~a, ~d}; // released lines show no stale value
   endtask : wr
   // single byte read, answer taken while it stands
   task rd(input logic [7:0] a, output logic [8:0] q);
      @(posedge clk_sys);
      #1;
      req = {2'b01, a, ~req.wdata};
      @(posedge clk_sys);
      #1;
      q = rsp;
      req = {2'b00, ~a, ~req.wdata};
   endtask : rd
endmodule : lccr_host

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   lccr_pkg::lccr_req_t req;
   lccr_pkg::lccr_evt_t evt_in = '0;
   lccr_pkg::lccr_rsp_t rsp;
   lccr_pkg::lccr_cfg_t cfg;
   lccr_pkg::lccr_evt_t eff;
   lccr_pkg::lccr_mode_t op_mode;
   logic fault_n, pin_out, pin_oe, mem_err;
   logic [8:0] rv;
   int error_cnt = 0;
   int n_compared = 0;
   logic [7:0] adr [5] = '{8'h10, 8'h13, 8'h15, 8'h16, 8'h1C};
   logic [7:0] msk [5] = '{8'h01, 8'hCC, 8'hFF, 8'hB3, 8'h07};
   logic [7:0] rstv [5] = '{8'h00, 8'h40, 8'h00, 8'h02, 8'h05};
   logic [5:0] gf [4] = '{6'h02, 6'h05, 6'h0A, 6'h32};
   logic [7:0] sim_wr [3] = '{8'h12, 8'h22, 8'h82};
   logic [3:0] sim_ev [3] = '{4'h2, 4'h1, 4'h8};
   // system clock
   always #4 clk_sys = ~clk_sys;
   lccr_host lccr_host_inst (.clk_sys(clk_sys), .rsp(rsp), .req(req));
   lccr_regs lccr_regs_inst (.clk_sys(clk_sys), .rst(rst), .req(req),
      .evt_in(evt_in), .rsp(rsp), .cfg(cfg), .eff_evt(eff),
      .fault_check_output_n(fault_n), .analog_input_pin_out(pin_out),
      .analog_input_pin_oe(pin_oe), .mem_error(mem_err), .op_mode(op_mode));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   // write, then let the applied outputs settle
   task put(input logic [7:0] a, input logic [7:0] d);
      lccr_host_inst.wr(a, d);
      cyc(1);
   endtask : put
   task rchk(input logic [7:0] a, input logic [7:0] d);
      lccr_host_inst.rd(a, rv);
      chk(rv, {1'b1, d});
   endtask : rchk
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   // hang guard
   initial begin
      #40000;
      error_cnt++;
      close_out;
   end
   // test sequence
   initial begin
      cyc(4);
      rst = 1'b0;
      for (int i = 0; i < 5; i++) rchk(adr[i], rstv[i]);
      chk({cfg.reference_swap, fault_n, pin_oe, mem_err}, 4'hC);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         put(adr[i], 8'hFF);
         rchk(adr[i], msk[i]);
      end
      chk({cfg.analog_mod_enable, cfg.laser_polarity_select,
         cfg.converter_drive_current}, 8'hFF);
      chk({mem_err, fault_n}, 2'b10);
      put(8'h20, 8'hFF);
      rchk(8'h20, 8'h00);
      put(8'h1C, 8'h04);
      chk(mem_err, 1'b1);
      put(8'h1C, 8'h05);
      chk({mem_err, op_mode}, {1'b0, lccr_pkg::LCCR_OPERATE});
      $display("test access done");
      for (int g = 0; g < 4; g++) begin
         put(8'h15, {g[1:0], 6'h15});
         chk({cfg.converter_drive_current, cfg.sense_gain_select,
            cfg.sense_gain_factor}, {6'h15, g[1:0], gf[g]});
      end
      put(8'h1C, 8'h06);
      put(8'h13, 8'h00);
      chk({op_mode, cfg.laser_polarity_select},
         {lccr_pkg::LCCR_CONFIG, 1'b1});
      rchk(8'h13, 8'h00);
      put(8'h1C, 8'h05);
      chk(cfg.laser_polarity_select, 1'b0);
      put(8'h1C, 8'h01);
      chk({pin_oe, pin_out}, 2'b10);
      put(8'h1C, 8'h05);
      chk(pin_oe, 1'b0);
      $display("test mode done");
      put(8'h10, 8'h01);
      put(8'h13, 8'h04);
      chk({cfg.control_mode_select, cfg.sense_range_select,
         cfg.laser_polarity_select}, 3'b110);
      put(8'h13, 8'h00);
      chk({cfg.sense_range_select, cfg.reference_swap},
         2'b00);
      put(8'h10, 8'h00);
      put(8'h13, 8'h80);
      chk({cfg.control_mode_select, cfg.laser_polarity_select},
         2'b01);
      $display("test setups done");
      put(8'h16, 8'h00);
      evt_in.osc_error = 1'b1;
      cyc(3);
      chk(fault_n, 1'b0);
      put(8'h16, 8'h01);
      chk(fault_n, 1'b1);
      evt_in = 4'h4;
      cyc(3);
      chk(fault_n, 1'b0);
      put(8'h16, 8'h03);
      chk(fault_n, 1'b1);
      evt_in = 4'h0;
      cyc(3);
      for (int i = 0; i < 3; i++) begin
         put(8'h16, sim_wr[i]);
         chk({eff, fault_n}, {sim_ev[i], 1'b0});
      end
      put(8'h16, 8'h02);
      chk({eff, fault_n}, 5'h01);
      $display("test faults done");
      close_out;
   end
endmodule : testbench
bind lccr_regs lccr_sva lccr_sva_inst (.clk_sys(clk_sys), .rst(rst),
   .req(req), .evt_in(evt_in), .rsp(rsp), .cfg(cfg), .eff_evt(eff_evt),
   .fault_check_output_n(fault_check_output_n),
   .analog_input_pin_out(analog_input_pin_out),
   .analog_input_pin_oe(analog_input_pin_oe), .mem_error(mem_error),
   .op_mode(op_mode));
